// ### phy_mgmt_consts.vh
`ifndef PHY_MGMT_CONSTS_VH
`define PHY_MGMT_CONSTS_VH

// Register numbers
`define REG_BASIC_CONTROL       5'h00
`define REG_BASIC_STATUS        5'h01
`define REG_PHY_IDENTITY_HIGH   5'h02
`define REG_PHY_IDENTITY_LOW    5'h03
`define REG_NEG_ADVERTISE       5'h04
`define REG_PARTNER_ABILITY     5'h05
`define REG_NEG_EXPANSION       5'h06
`define REG_NEG_NEXT_PAGE       5'h07
`define REG_PARTNER_NEXT_PAGE   5'h08
`define REG_MAC_IF_CONTROL      5'h14
`define REG_RX_ERROR_COUNTER    5'h15
`define REG_INT_CONTROL_STATUS  5'h1B
`define REG_PHY_CONTROL_ONE     5'h1E
`define REG_PHY_CONTROL_TWO     5'h1F

// Basic control bit positions
`define CTL_SOFT_RESET          15
`define CTL_LOOPBACK            14
`define CTL_SPEED_100           13
`define CTL_NEG_ENABLE          12
`define CTL_POWER_DOWN          11
`define CTL_ISOLATE             10
`define CTL_NEG_RESTART         9
`define CTL_FULL_DUPLEX         8
`define CTL_COL_TEST            7
`define CTL_TX_DISABLE          0

// Basic status: fixed capability bits, live bit positions
`define STATUS_FIXED            16'h7849
`define STS_NEG_COMPLETE        5
`define STS_LINK_UP             2

// Reset values of plain control bits
`define CTL_LOOPBACK_RST        1'b0
`define CTL_POWER_DOWN_RST      1'b0
`define CTL_COL_TEST_RST        1'b0
`define CTL_TX_DISABLE_RST      1'b0

// Management frame
`define OP_READ                 2'h2
`define OP_WRITE                2'h1
`define HDR_BITS                5'h0C
`define DATA_BITS               5'h10
`define PHY_ADDR_DEFAULT        5'h01

`endif

// ### mgmt_word_store.v
`timescale 1ns/100ps
module mgmt_word_store #(
    parameter DATA_W = 16,
    parameter ADDR_W = 5
) (
    input  wire              clk_i,
    input  wire              wr_en_i,
    input  wire [ADDR_W-1:0] wr_addr_i,
    input  wire [DATA_W-1:0] wr_data_i,
    input  wire [ADDR_W-1:0] rd_addr_i,
    output reg  [DATA_W-1:0] rd_data_o
);
    reg [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

    always @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_reg[rd_addr_i];
    end
endmodule // mgmt_word_store

// ### phy_basic_mgmt_registers.v
`timescale 1ns/100ps
`include "phy_mgmt_consts.vh"

// Notes on behaviour
// - Registers 0-8, 14h, 15h, 1Bh, 1Eh, 1Fh decode; other numbers are reserved.
// - Writing one to control bit 15 resets the transceiver; bit clears itself.
// - Speed bit 13 (1 = 100Mbps) is ignored while auto-negotiation is enabled.
// - With bit 12 set, negotiated speed and duplex replace bits 13 and 8.
// - Speed bit loads from the speed strap after reset.
// - Negotiation enable bit loads from the negotiation strap after reset.
// - Bit 10 isolates the device from MAC interface and line transmitter.
// - Isolate bit loads from the isolation strap after reset.
// - Writing one to bit 9 restarts negotiation; bit clears itself.
// - Bit 8 selects full duplex; resets to the inverse of the duplex strap.
// - Bit 7 enables the collision test; resets to zero.
// - Bit 0 disables the line transmitter; resets to zero.
// - Status bit 15 reads zero, bit 14 reads one.
// - Status bit 13 is read-only and reads one.
// - Power-down stops everything except management; registers stay accessible.
module phy_basic_mgmt_registers #(
    parameter [4:0]  PHY_ADDR      = `PHY_ADDR_DEFAULT,
    parameter [15:0] IDENTITY_HIGH = 16'h1234, // Arbitrary value
    parameter [15:0] IDENTITY_LOW  = 16'h5678  // Arbitrary value
) (
    input  wire clk_i,
    input  wire nrst_i,
    input  wire mdc_i,
    input  wire mdio_i,
    output reg  mdio_o,
    output reg  mdio_oe_n_o,
    input  wire speed_strap_i,
    input  wire negotiation_enable_strap_i,
    input  wire isolate_strap_i,
    input  wire duplex_strap_i,
    input  wire neg_speed_100_i,
    input  wire neg_full_duplex_i,
    input  wire neg_complete_i,
    input  wire link_up_i,
    input  wire receive_error_i,
    output reg  soft_reset_o,
    output reg  neg_restart_o,
    output reg  neg_enable_o,
    output reg  speed_100_o,
    output reg  full_duplex_o,
    output reg  loopback_o,
    output reg  isolate_o,
    output reg  tx_disable_o,
    output reg  col_test_o,
    output reg  core_enable_o
);
    localparam S_IDLE  = 5'h01;
    localparam S_START = 5'h02;
    localparam S_HDR   = 5'h04;
    localparam S_TA    = 5'h08;
    localparam S_DATA  = 5'h10;
    localparam NPIN    = 6;

    // Pin synchronisers: mdc, mdio, four straps
    wire [NPIN-1:0] pin_raw = {duplex_strap_i, isolate_strap_i, negotiation_enable_strap_i,
                               speed_strap_i, mdio_i, mdc_i};
    reg  [NPIN-1:0] sync1_reg;
    reg  [NPIN-1:0] sync2_reg;
    reg  [NPIN-1:0] sync3_reg;
    reg  [NPIN-1:0] pin_reg;
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1) begin : g_sync
            // No reset: strap levels must be valid while reset is held
            always @(posedge clk_i) begin
                sync1_reg[g] <= pin_raw[g];
                sync2_reg[g] <= sync1_reg[g];
                sync3_reg[g] <= sync2_reg[g];
                if (sync2_reg[g] == sync3_reg[g]) begin
                    pin_reg[g] <= sync3_reg[g];
                end
            end
        end
    endgenerate

    wire mdc_f   = pin_reg[0];
    wire mdio_f  = pin_reg[1];
    wire s_speed = pin_reg[2];
    wire s_neg   = pin_reg[3];
    wire s_iso   = pin_reg[4];
    wire s_dup   = pin_reg[5];

    reg  mdc_prev_reg;
    wire mdc_rise = mdc_f & ~mdc_prev_reg;

    // Frame state
    reg  [4:0]  state_reg;
    reg  [4:0]  cnt_reg;
    reg  [11:0] hdr_reg;
    reg  [15:0] shift_reg;
    reg         rd_reg;
    reg         wr_reg;
    wire [1:0]  op_w   = hdr_reg[11:10];
    wire [4:0]  phy_w  = hdr_reg[9:5];
    wire [4:0]  regad  = hdr_reg[4:0];
    wire [11:0] hdr_nx = {hdr_reg[10:0], mdio_f};
    wire [15:0] data_nx = {shift_reg[14:0], mdio_f};

    // Control register fields
    reg ctl_speed_reg;
    reg ctl_neg_reg;
    reg ctl_pd_reg;
    reg ctl_iso_reg;
    reg ctl_dup_reg;
    reg ctl_col_reg;
    reg ctl_loop_reg;
    reg ctl_txdis_reg;
    reg [15:0] rxerr_cnt_reg;
    reg [5:0]  written_reg;

    // Writable registers outside the basic pair live in the word store
    reg  [5:0] wr_slot;
    always @* begin
        case (regad)
            `REG_NEG_ADVERTISE:      wr_slot = 6'h01;
            `REG_NEG_NEXT_PAGE:      wr_slot = 6'h02;
            `REG_MAC_IF_CONTROL:     wr_slot = 6'h04;
            `REG_INT_CONTROL_STATUS: wr_slot = 6'h08;
            `REG_PHY_CONTROL_ONE:    wr_slot = 6'h10;
            `REG_PHY_CONTROL_TWO:    wr_slot = 6'h20;
            default:                 wr_slot = 6'h00;
        endcase
    end

    wire        commit    = mdc_rise && state_reg == S_DATA && wr_reg &&
                            cnt_reg == `DATA_BITS - 5'h01;
    wire        store_wr  = commit && (wr_slot != 6'h00);
    wire [15:0] store_rd;

    mgmt_word_store #(
        .DATA_W(16),
        .ADDR_W(5)
    ) u_store (
        .clk_i    (clk_i),
        .wr_en_i  (store_wr),
        .wr_addr_i(regad),
        .wr_data_i(data_nx),
        .rd_addr_i(regad),
        .rd_data_o(store_rd)
    );

    wire [15:0] ctl_word = {1'b0, ctl_loop_reg, ctl_speed_reg, ctl_neg_reg, ctl_pd_reg,
                            ctl_iso_reg, 1'b0, ctl_dup_reg, ctl_col_reg, 6'h00,
                            ctl_txdis_reg};
    reg  [15:0] sts_word;
    reg  [15:0] rd_word;
    always @* begin
        sts_word = `STATUS_FIXED;
        sts_word[`STS_NEG_COMPLETE] = neg_complete_i;
        sts_word[`STS_LINK_UP] = link_up_i;
        case (regad)
            `REG_BASIC_CONTROL:     rd_word = ctl_word;
            `REG_BASIC_STATUS:      rd_word = sts_word;
            `REG_PHY_IDENTITY_HIGH: rd_word = IDENTITY_HIGH;
            `REG_PHY_IDENTITY_LOW:  rd_word = IDENTITY_LOW;
            `REG_RX_ERROR_COUNTER:  rd_word = rxerr_cnt_reg;
            // Never-written slots read zero instead of unknown memory
            default: rd_word = ((wr_slot & written_reg) != 6'h00) ? store_rd : 16'h0000;
        endcase
    end

    // Management frame engine
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            mdc_prev_reg <= 1'b0;
            state_reg    <= S_IDLE;
            cnt_reg      <= 5'h00;
            hdr_reg      <= 12'h000;
            shift_reg    <= 16'h0000;
            rd_reg       <= 1'b0;
            wr_reg       <= 1'b0;
            mdio_o       <= 1'b1;
            mdio_oe_n_o  <= 1'b1;
        end else begin
            mdc_prev_reg <= mdc_f;
            if (mdc_rise) begin
                case (state_reg)
                    S_IDLE: begin
                        if (!mdio_f) begin
                            state_reg <= S_START;
                        end
                    end
                    S_START: begin
                        cnt_reg   <= 5'h00;
                        state_reg <= mdio_f ? S_HDR : S_IDLE;
                    end
                    S_HDR: begin
                        hdr_reg <= hdr_nx;
                        cnt_reg <= cnt_reg + 5'h01;
                        if (cnt_reg == `HDR_BITS - 5'h01) begin
                            rd_reg    <= hdr_nx[11:10] == `OP_READ && hdr_nx[9:5] == PHY_ADDR;
                            wr_reg    <= hdr_nx[11:10] == `OP_WRITE && hdr_nx[9:5] == PHY_ADDR;
                            cnt_reg   <= 5'h00;
                            state_reg <= S_TA;
                        end
                    end
                    S_TA: begin
                        cnt_reg <= cnt_reg + 5'h01;
                        if (cnt_reg == 5'h00) begin
                            if (rd_reg) begin
                                mdio_o      <= 1'b0;
                                mdio_oe_n_o <= 1'b0;
                            end
                        end else begin
                            cnt_reg   <= 5'h00;
                            shift_reg <= rd_word;
                            state_reg <= S_DATA;
                            if (rd_reg) begin
                                mdio_o <= rd_word[15];
                            end
                        end
                    end
                    S_DATA: begin
                        cnt_reg <= cnt_reg + 5'h01;
                        if (rd_reg) begin
                            shift_reg <= {shift_reg[14:0], 1'b0};
                            mdio_o    <= shift_reg[14];
                        end else begin
                            shift_reg <= data_nx;
                        end
                        if (cnt_reg == `DATA_BITS - 5'h01) begin
                            mdio_o      <= 1'b1;
                            mdio_oe_n_o <= 1'b1;
                            rd_reg      <= 1'b0;
                            wr_reg      <= 1'b0;
                            state_reg   <= S_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // Basic control register; soft reset restores the strap defaults
    wire ctl_wr  = commit && regad == `REG_BASIC_CONTROL;
    wire do_init = !nrst_i || soft_reset_o;
    always @(posedge clk_i) begin
        if (do_init) begin
            ctl_speed_reg <= s_speed;
            ctl_neg_reg   <= s_neg;
            ctl_iso_reg   <= s_iso;
            ctl_dup_reg   <= ~s_dup;
            ctl_pd_reg    <= `CTL_POWER_DOWN_RST;
            ctl_col_reg   <= `CTL_COL_TEST_RST;
            ctl_loop_reg  <= `CTL_LOOPBACK_RST;
            ctl_txdis_reg <= `CTL_TX_DISABLE_RST;
            soft_reset_o  <= 1'b0;
            neg_restart_o <= 1'b0;
            written_reg   <= 6'h00;
            rxerr_cnt_reg <= 16'h0000;
        end else begin
            // Command bits are one-cycle pulses, never stored
            soft_reset_o  <= ctl_wr && data_nx[`CTL_SOFT_RESET];
            neg_restart_o <= ctl_wr && data_nx[`CTL_NEG_RESTART];
            if (ctl_wr) begin
                ctl_loop_reg  <= data_nx[`CTL_LOOPBACK];
                ctl_speed_reg <= data_nx[`CTL_SPEED_100];
                ctl_neg_reg   <= data_nx[`CTL_NEG_ENABLE];
                ctl_pd_reg    <= data_nx[`CTL_POWER_DOWN];
                ctl_iso_reg   <= data_nx[`CTL_ISOLATE];
                ctl_dup_reg   <= data_nx[`CTL_FULL_DUPLEX];
                ctl_col_reg   <= data_nx[`CTL_COL_TEST];
                ctl_txdis_reg <= data_nx[`CTL_TX_DISABLE];
            end
            if (store_wr) begin
                written_reg <= written_reg | wr_slot;
            end
            // Saturates rather than wraps; counting stops in power-down
            if (receive_error_i && !ctl_pd_reg && rxerr_cnt_reg != 16'hFFFF) begin
                rxerr_cnt_reg <= rxerr_cnt_reg + 16'h0001;
            end
        end
    end

    // Effective datapath controls
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            neg_enable_o  <= 1'b0;
            speed_100_o   <= 1'b0;
            full_duplex_o <= 1'b0;
            loopback_o    <= 1'b0;
            isolate_o     <= 1'b0;
            tx_disable_o  <= 1'b0;
            col_test_o    <= 1'b0;
            core_enable_o <= 1'b0;
        end else begin
            neg_enable_o  <= ctl_neg_reg;
            speed_100_o   <= ctl_neg_reg ? neg_speed_100_i : ctl_speed_reg;
            full_duplex_o <= ctl_neg_reg ? neg_full_duplex_i : ctl_dup_reg;
            loopback_o    <= ctl_loop_reg;
            isolate_o     <= ctl_iso_reg;
            tx_disable_o  <= ctl_txdis_reg | ctl_iso_reg;
            col_test_o    <= ctl_col_reg;
            // Management engine above never looks at power-down
            core_enable_o <= ~ctl_pd_reg;
        end
    end
endmodule // phy_basic_mgmt_registers

// ### mgmt_station.sv
`timescale 1ns/100ps
module mgmt_station (
    input  wire logic mdio_i,
    output logic      mdc_o,
    output logic      drv_en_o,
    output logic      drv_o
);
    initial begin
        mdc_o = 1'h0;
        drv_en_o = 1'h0;
        drv_o = 1'h1;
    end
    // Clock runs only inside a frame; its phase stays off the core clock edges
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [31:0] w;
        w = {2'h1, op, phy, ra, 2'h2, wd};
        rd = 16'h0000;
        #37;
        for (int k = 0; k < 32; k++) begin
            #200 drv_en_o = (k < 14) || (op == 2'h1);
            drv_o = w[31-k];
            #200 if (k >= 16) rd[31-k] = mdio_i;
            mdc_o = 1'h1;
            #400 mdc_o = 1'h0;
        end
        drv_en_o = 1'h0;
        #1600;
    endtask
endmodule // mgmt_station

// ### phy_mgmt_chk.sv
`timescale 1ns/100ps
module phy_mgmt_chk (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic soft_reset_o,
    input wire logic neg_restart_o,
    input wire logic neg_enable_o,
    input wire logic speed_100_o,
    input wire logic full_duplex_o,
    input wire logic isolate_o,
    input wire logic tx_disable_o,
    input wire logic mdio_oe_n_o,
    input wire logic neg_speed_100_i,
    input wire logic neg_full_duplex_i,
    input wire logic speed_strap_i,
    input wire logic negotiation_enable_strap_i,
    input wire logic isolate_strap_i,
    input wire logic duplex_strap_i
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    // Three quiet cycles cover the output register delay
    sequence neg_held(s);
        (neg_enable_o && $stable(neg_enable_o) && $stable(s)) [*3];
    endsequence
    sequence released;
        $rose(nrst_i);
    endsequence
    a_reset_pulse: assert property (soft_reset_o |=> !soft_reset_o)
        else $error("soft reset pulse too long");
    a_restart_pulse: assert property (neg_restart_o |=> !neg_restart_o)
        else $error("restart pulse too long");
    a_neg_speed: assert property (
        neg_held(neg_speed_100_i) |-> speed_100_o == neg_speed_100_i)
        else $error("speed not from negotiation");
    a_neg_duplex: assert property (
        neg_held(neg_full_duplex_i) |-> full_duplex_o == neg_full_duplex_i)
        else $error("duplex not from negotiation");
    a_isolate_tx: assert property (isolate_o |-> tx_disable_o)
        else $error("isolated but transmitter on");
    a_strap_neg: assert property (
        released |=> neg_enable_o == negotiation_enable_strap_i && isolate_o == isolate_strap_i)
        else $error("strap not loaded");
    a_strap_manual: assert property (
        released ##0 !negotiation_enable_strap_i |=>
            speed_100_o == speed_strap_i && full_duplex_o == !duplex_strap_i)
        else $error("speed or duplex strap not loaded");
    a_reset_quiet: assert property (
        released |-> !soft_reset_o && !neg_restart_o && mdio_oe_n_o)
        else $error("outputs not quiet after reset");
endmodule // phy_mgmt_chk

bind phy_basic_mgmt_registers phy_mgmt_chk u_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .soft_reset_o(soft_reset_o),
    .neg_restart_o(neg_restart_o), .neg_enable_o(neg_enable_o), .speed_100_o(speed_100_o),
    .full_duplex_o(full_duplex_o), .isolate_o(isolate_o), .tx_disable_o(tx_disable_o),
    .mdio_oe_n_o(mdio_oe_n_o), .neg_speed_100_i(neg_speed_100_i),
    .neg_full_duplex_i(neg_full_duplex_i), .speed_strap_i(speed_strap_i),
    .negotiation_enable_strap_i(negotiation_enable_strap_i),
    .isolate_strap_i(isolate_strap_i), .duplex_strap_i(duplex_strap_i));

// ### testbench.sv
`timescale 1ns/100ps
`include "phy_mgmt_consts.vh"
module testbench;
    logic       clk_i, nrst_i, mdc, drv_en, drv, mdio_o, mdio_oe_n_o;
    logic [3:0] strap;
    logic       ns, nd, nc, lu, rx_err;
    logic       sr_o, rs_o, ne_o, sp_o, fd_o, lb_o, is_o, td_o, ct_o, ce_o;
    int         fails, checked, seed, n_sr, n_rs;
    // Pull-up holds the data line high when nobody drives it
    wire        mdio_w = drv_en ? drv : (mdio_oe_n_o ? 1'h1 : mdio_o);

    phy_basic_mgmt_registers DUT (
        .clk_i(clk_i), .nrst_i(nrst_i), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o),
        .mdio_oe_n_o(mdio_oe_n_o), .speed_strap_i(strap[3]),
        .negotiation_enable_strap_i(strap[2]), .isolate_strap_i(strap[1]),
        .duplex_strap_i(strap[0]), .neg_speed_100_i(ns), .neg_full_duplex_i(nd),
        .neg_complete_i(nc), .link_up_i(lu), .receive_error_i(rx_err), .soft_reset_o(sr_o),
        .neg_restart_o(rs_o), .neg_enable_o(ne_o), .speed_100_o(sp_o), .full_duplex_o(fd_o),
        .loopback_o(lb_o), .isolate_o(is_o), .tx_disable_o(td_o), .col_test_o(ct_o),
        .core_enable_o(ce_o));
    mgmt_station mgr (.mdio_i(mdio_w), .mdc_o(mdc), .drv_en_o(drv_en), .drv_o(drv));

    initial begin
        clk_i = 1'h0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (sr_o === 1'h1) n_sr++;
        if (rs_o === 1'h1) n_rs++;
    end

    localparam logic [15:0] ID_HIGH = 16'h1234; // Arbitrary value
    localparam logic [15:0] ID_LOW  = 16'h5678; // Arbitrary value

    function automatic logic [15:0] strap_ctl();
        return {2'h0, strap[3], strap[2], 1'h0, strap[1], 1'h0, ~strap[0], 8'h00};
    endfunction
    // Isolate also forces the transmitter off
    function automatic logic [15:0] ctl_out(input logic [15:0] c);
        return {10'h000, c[14], c[12], c[10], c[0] | c[10], c[7], ~c[11]};
    endfunction
    function automatic logic [15:0] speed_dup(input logic [15:0] c);
        return {14'h0000, c[12] ? {ns, nd} : {c[13], c[8]}};
    endfunction
    function automatic logic [15:0] map_exp(input int r, input logic [15:0] c);
        if (r == 2)
            return ID_HIGH;
        if (r == 3)
            return ID_LOW;
        if (r == 4 || r == 7 || r == 20 || r == 27 || r >= 30)
            return c;
        return 16'h0000;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        mgr.frame(op, phy, ra, wd, rd);
        @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] x;
        xfer(`OP_WRITE, `PHY_ADDR_DEFAULT, ra, wd, x);
    endtask
    task automatic rd(input logic [4:0] ra, output logic [15:0] v);
        xfer(`OP_READ, `PHY_ADDR_DEFAULT, ra, 16'h0000, v);
    endtask
    task automatic wrap_up();
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        fails++;
        wrap_up();
    end

    initial begin
        logic [15:0] v, d, o;
        seed = 93;
        fails = 0;
        checked = 0;
        n_sr = 0;
        n_rs = 0;
        nrst_i = 1'h0;
        rx_err = 1'h0;
        {ns, nd, nc, lu, strap} = 8'($random(seed));
        repeat (6) @(posedge clk_i);
        #1 nrst_i = 1'h1;
        rd(`REG_BASIC_CONTROL, v);
        check(v, strap_ctl(), "reset control");
        wr(`REG_BASIC_STATUS, 16'h0000);
        rd(`REG_BASIC_STATUS, v);
        check(v, 16'h7849 | {10'h000, nc, 2'h0, lu, 2'h0}, "status");
        // First pass sets every stored bit, reserved ones too, but not command bits 15 and 9
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 16'h7DFF : 16'($random(seed)) & 16'h7DFF;
            wr(`REG_BASIC_CONTROL, d);
            {ns, nd} = 2'($random(seed));
            rd(`REG_BASIC_CONTROL, v);
            check(v, d & 16'h7D81, "control readback");
            o = {10'h000, lb_o, ne_o, is_o, td_o, ct_o, ce_o};
            check(o, ctl_out(d), "controls");
            check({14'h0000, sp_o, fd_o}, speed_dup(d), "speed duplex");
        end
        wr(`REG_BASIC_CONTROL, 16'h1200);
        rd(`REG_BASIC_CONTROL, v);
        check(v, 16'h1000, "restart clears");
        check(16'(n_rs), 16'h0001, "restart pulses");
        for (int r = 0; r < 32; r++) begin
            // Identity and partner registers must ignore the write too
            if (r <= 1 || r == 21) continue;
            d = 16'($random(seed));
            wr(r[4:0], d);
            rd(r[4:0], v);
            check(v, map_exp(r, d), "register map");
        end
        // Frames to another station address or with a bad opcode change nothing
        wr(`REG_NEG_ADVERTISE, 16'hA5C3);
        xfer(`OP_WRITE, 5'h02, `REG_NEG_ADVERTISE, 16'h5A3C, v);
        xfer(2'h3, `PHY_ADDR_DEFAULT, `REG_NEG_ADVERTISE, 16'h0F0F, v);
        rd(`REG_NEG_ADVERTISE, v);
        check(v, 16'hA5C3, "foreign frame");
        for (int i = 0; i < 3; i++) begin
            rx_err = 1'h1;
            @(posedge clk_i);
            #1 rx_err = 1'h0;
            @(posedge clk_i);
            #1;
        end
        rd(`REG_RX_ERROR_COUNTER, v);
        check(v, 16'h0003, "error count");
        wr(`REG_BASIC_CONTROL, 16'h8000);
        check(16'(n_sr), 16'h0001, "soft reset pulses");
        rd(`REG_BASIC_CONTROL, v);
        check(v, strap_ctl(), "control after soft reset");
        wrap_up();
    end
endmodule // testbench
